// >>> logic/motion_cmd_pkg.sv
package motion_cmd_pkg;

   // ==========================================================
   // command codes on the command port
   localparam logic [7:0] CMD_TRAJ_START = 8'h01;
   localparam logic [7:0] CMD_TRAJ_LOAD  = 8'h1F;
   localparam logic [7:0] CMD_MASK       = 8'h1C;
   localparam logic [7:0] CMD_FLAG_CLEAR = 8'h1D;
   localparam logic [7:0] CMD_BP_ABS     = 8'h20;
   localparam logic [7:0] CMD_BP_REL     = 8'h21;

   // ==========================================================
   // status byte layout and reset values
   localparam int         ST_BUSY        = 0;
   localparam int         ST_COND_LO     = 1;
   localparam int         ST_BREAKPOINT  = 6;
   localparam logic [7:0] STATUS_RST     = 8'h00;
   localparam logic [7:0] MASK_RST       = 8'h00;

   // ==========================================================
   // trajectory control word fields
   localparam int         CW_FWD         = 12;
   localparam int         CW_VEL_MODE    = 11;
   localparam int         CW_ACC_LD      = 5;
   localparam int         CW_LD_STEP     = 2;
   localparam int         PAR_COUNT      = 3;
   localparam int         FRAC_BITS      = 16;
   localparam logic [7:0] CW_LOAD_FLAGS  = 8'h3F;

   // ==========================================================
   // timing
   localparam int         CLK_PERIOD_NS  = 10;
   localparam int         BUSY_TIME_NS   = 100;
   localparam int         BUSY_CYCLES    = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         SAMPLE_CLKS    = 2048;
   localparam int         SAMPLE_CNT_W   = 11;

   // ==========================================================
   // types
   typedef struct packed {
      logic       cmd_wr;
      logic       data_wr;
      logic [7:0] data;
   } host_in_type;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [31:0] accel;
      logic [31:0] vel;
      logic [31:0] pos;
   } traj_type;

   typedef enum logic [5:0] {
      PH_CMD      = 6'b00_0001,
      PH_MASK     = 6'b00_0010,
      PH_BP       = 6'b00_0100,
      PH_TRJ_CW   = 6'b00_1000,
      PH_TRJ_PAR  = 6'b01_0000,
      PH_CLEAR    = 6'b10_0000
   } phase_type;

   typedef struct packed {
      phase_type         phase;
      host_in_type       hin_d;
      logic              byte_hi;
      logic [7:0]        hi_byte;
      logic              word_n;
      logic [15:0]       word_hi;
      logic              bp_rel;
      logic [1:0]        par_sel;
      logic [15:0]       cw_buf;
      logic [31:0]       acc_buf;
      logic [31:0]       vel_buf;
      logic [31:0]       pos_buf;
      traj_type          act;
      logic              start_p;
      logic [7:0]        mask;
      logic [7:0]        status;
      logic              irq;
      logic [7:0]        busy_cnt;
      logic [SAMPLE_CNT_W-1:0] samp_cnt;
      logic [31:0]       bp;
      logic              bp_armed;
      logic              bp_prev_valid;
      logic              bp_prev_sign;
   } cmd_state_type;

endpackage : motion_cmd_pkg

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// two-stage synchroniser; stage 0 is read only by stage 1
module pin_sync #(
   parameter int W = 1
) (
   // clock, reset, enable
   input  wire  logic         sys_clk,
   input  wire  logic         rst_b,
   input  wire  logic         clk_en,
   // pins and synchronised copy
   input  wire  logic [W-1:0] pin_in,
   output var   logic [W-1:0] pin_sync_out
);

   logic [1:0][W-1:0] stage_r;
   logic [1:0][W-1:0] stage_nxt;

   always_comb begin
      stage_nxt    = stage_r;
      stage_nxt[0] = pin_in;
      stage_nxt[1] = stage_r[0];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_r <= '0;
      end else if (clk_en) begin
         stage_r <= stage_nxt;
      end
   end

   assign pin_sync_out = stage_r[1];

endmodule : pin_sync

`default_nettype wire

// >>> logic/motion_host_cmd.sv
// Behaviour
// - mask command takes exactly one data word
// - mask high byte ignored; low bits 1-6 enable
// - mask gates interrupt only, status shows everything
// - breakpoint reached sets status bit six, interrupts if mask bit six is set
// - mask low byte 40 enables only breakpoint
// - absolute breakpoint value is absolute shaft position
// - code 20 starts absolute breakpoint load
// - code 21 adds value to target position
// - breakpoint is 32 bits, high word first
// - words move as high byte then low byte
// - code 1F loads control word then parameters
// - control high byte 18 is forward velocity
// - low byte 28: absolute acceleration and velocity
// - 180C: relative velocity only follows
// - relative velocity adds to programmed velocity
// - acceleration and velocity carry 16 fractional bits
// - parameters are 32-bit, two words, two's complement
// - parameters take effect only on start code 01
// - code 1D word: zero bits clear flags
`timescale 1ns/1ps
`default_nettype none

module motion_host_cmd (
   // clock, reset, enable
   input  wire  logic                      sys_clk,
   input  wire  logic                      rst_b,
   input  wire  logic                      clk_en,
   // host command and data port, asynchronous
   input  wire  logic                      host_cmd_wr,
   input  wire  logic                      host_data_wr,
   input  wire  logic [7:0]                host_data,
   // position and condition inputs from neighbouring logic
   input  wire  logic [31:0]               actual_pos,
   input  wire  logic [31:0]               target_pos,
   input  wire  logic [5:1]                cond_evt,
   // status, host interrupt, trajectory outputs
   output var   logic [7:0]                status,
   output var   logic                      host_irq,
   output var   motion_cmd_pkg::traj_type  traj_act,
   output var   logic                      traj_start
);
   import motion_cmd_pkg::*;

   cmd_state_type st_r;
   cmd_state_type st_nxt;
   host_in_type   hin;
   logic          cmd_evt;
   logic          data_evt;
   logic          word_done;
   logic [15:0]   word;
   logic [31:0]   val32;
   logic          tick;
   logic [31:0]   bp_diff;
   logic          bp_hit;
   logic          bp_load;
   logic [31:0]   bp_new;
   logic [7:0]    clr_bits;

   // ==========================================================
   // host pins: the data byte is synchronised with its strobe, so
   // the host must hold data steady a few clocks around the strobe
   pin_sync #(
      .W            ($bits(host_in_type))
   ) u_host_sync (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .clk_en       (clk_en),
      .pin_in       ({host_cmd_wr, host_data_wr, host_data}),
      .pin_sync_out (hin)
   );

   // ==========================================================
   // transfer detection; edges during busy are dropped
   assign cmd_evt   = hin.cmd_wr & ~st_r.hin_d.cmd_wr & ~st_r.status[ST_BUSY];
   assign data_evt  = hin.data_wr & ~st_r.hin_d.data_wr & ~st_r.status[ST_BUSY];
   assign word_done = data_evt & st_r.byte_hi;
   assign word      = {st_r.hi_byte, hin.data};
   assign val32     = {st_r.word_hi, word};

   // ==========================================================
   // breakpoint compare, once per sample; a crossing counts too,
   // since the shaft may pass the point between two samples
   assign tick    = (st_r.samp_cnt == SAMPLE_CNT_W'(SAMPLE_CLKS - 1));
   assign bp_diff = actual_pos - st_r.bp;
   assign bp_hit  = tick & st_r.bp_armed &
                    ((bp_diff == 32'h0000_0000) |
                     (st_r.bp_prev_valid & (bp_diff[31] != st_r.bp_prev_sign)));
   assign bp_load = (st_r.phase == PH_BP) & word_done & st_r.word_n;
   assign bp_new  = st_r.bp_rel ? (target_pos + val32) : val32;

   // first selected parameter at or after 'from': {found, index}
   function automatic logic [2:0] next_par(input logic [15:0] cw, input int from);
      logic [2:0] r;
      r = '0;
      for (int i = PAR_COUNT - 1; i >= 0; i--) begin
         if (i >= from && cw[CW_ACC_LD - CW_LD_STEP * i]) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction : next_par

   // ==========================================================
   // next state
   always_comb begin
      logic [2:0] np;
      np              = '0;
      st_nxt          = st_r;
      st_nxt.hin_d    = hin;
      st_nxt.start_p  = 1'b0;
      clr_bits        = '0;

      st_nxt.samp_cnt = tick ? '0 : st_r.samp_cnt + 1'b1;
      if (st_r.busy_cnt != 8'h00) begin
         st_nxt.busy_cnt = st_r.busy_cnt - 1'b1;
      end

      if (cmd_evt) begin
         st_nxt.busy_cnt = 8'(BUSY_CYCLES);
         st_nxt.byte_hi  = 1'b0;
         st_nxt.word_n   = 1'b0;
         st_nxt.phase    = PH_CMD;
         case (hin.data)
            CMD_MASK:       st_nxt.phase = PH_MASK;
            CMD_FLAG_CLEAR: st_nxt.phase = PH_CLEAR;
            CMD_TRAJ_LOAD:  st_nxt.phase = PH_TRJ_CW;
            CMD_BP_ABS: begin
               st_nxt.phase  = PH_BP;
               st_nxt.bp_rel = 1'b0;
            end
            CMD_BP_REL: begin
               st_nxt.phase  = PH_BP;
               st_nxt.bp_rel = 1'b1;
            end
            CMD_TRAJ_START: begin
               st_nxt.start_p  = 1'b1;
               st_nxt.act.ctrl = st_r.cw_buf;
               if (st_r.cw_buf[CW_ACC_LD]) begin
                  st_nxt.act.accel = st_r.cw_buf[CW_ACC_LD - 1] ?
                                     st_r.act.accel + st_r.acc_buf : st_r.acc_buf;
               end
               // velocity is 16.16 fixed point; a relative value adds
               if (st_r.cw_buf[CW_ACC_LD - CW_LD_STEP]) begin
                  st_nxt.act.vel = st_r.cw_buf[CW_ACC_LD - CW_LD_STEP - 1] ?
                                   st_r.act.vel + st_r.vel_buf : st_r.vel_buf;
               end
               if (st_r.cw_buf[CW_ACC_LD - 2 * CW_LD_STEP]) begin
                  st_nxt.act.pos = st_r.cw_buf[CW_ACC_LD - 2 * CW_LD_STEP - 1] ?
                                   target_pos + st_r.pos_buf : st_r.pos_buf;
               end
               // consumed: a second start must not add relative values again
               st_nxt.cw_buf[7:0] = st_r.cw_buf[7:0] & ~CW_LOAD_FLAGS;
            end
            default: st_nxt.phase = PH_CMD;
         endcase
      end else if (data_evt && !st_r.byte_hi) begin
         st_nxt.hi_byte = hin.data;
         st_nxt.byte_hi = 1'b1;
      end else if (word_done) begin
         st_nxt.byte_hi  = 1'b0;
         st_nxt.busy_cnt = 8'(BUSY_CYCLES);
         unique case (st_r.phase)
            PH_CMD: st_nxt.phase = PH_CMD;
            PH_MASK: begin
               st_nxt.mask  = {1'b0, word[ST_BREAKPOINT:ST_COND_LO], 1'b0};
               st_nxt.phase = PH_CMD;
            end
            PH_CLEAR: begin
               clr_bits     = {1'b0, ~word[ST_BREAKPOINT:ST_COND_LO], 1'b0};
               st_nxt.phase = PH_CMD;
            end
            PH_BP: begin
               if (!st_r.word_n) begin
                  st_nxt.word_hi = word;
                  st_nxt.word_n  = 1'b1;
               end else begin
                  st_nxt.bp            = bp_new;
                  st_nxt.bp_armed      = 1'b1;
                  st_nxt.bp_prev_valid = 1'b0;
                  st_nxt.word_n        = 1'b0;
                  st_nxt.phase         = PH_CMD;
               end
            end
            PH_TRJ_CW: begin
               st_nxt.cw_buf = word;
               np            = next_par(word, 0);
               st_nxt.par_sel = np[1:0];
               st_nxt.word_n  = 1'b0;
               st_nxt.phase   = np[2] ? PH_TRJ_PAR : PH_CMD;
            end
            PH_TRJ_PAR: begin
               if (!st_r.word_n) begin
                  st_nxt.word_hi = word;
                  st_nxt.word_n  = 1'b1;
               end else begin
                  st_nxt.word_n = 1'b0;
                  unique case (st_r.par_sel)
                     2'd0:    st_nxt.acc_buf = val32;
                     2'd1:    st_nxt.vel_buf = val32;
                     default: st_nxt.pos_buf = val32;
                  endcase
                  np             = next_par(st_r.cw_buf, int'(st_r.par_sel) + 1);
                  st_nxt.par_sel = np[1:0];
                  st_nxt.phase   = np[2] ? PH_TRJ_PAR : PH_CMD;
               end
            end
            default: st_nxt.phase = PH_CMD;
         endcase
      end

      if (tick && st_r.bp_armed) begin
         st_nxt.bp_prev_valid = 1'b1;
         st_nxt.bp_prev_sign  = bp_diff[31];
      end
      if (bp_hit) begin
         st_nxt.bp_armed = 1'b0;
      end

      // flags: clear first, then set, so an event in the clear cycle survives
      st_nxt.status = st_r.status & ~clr_bits;
      st_nxt.status[ST_BREAKPOINT-1:ST_COND_LO] =
         st_nxt.status[ST_BREAKPOINT-1:ST_COND_LO] | cond_evt;
      if (bp_hit) begin
         st_nxt.status[ST_BREAKPOINT] = 1'b1;
      end
      st_nxt.status[ST_BUSY] = (st_nxt.busy_cnt != 8'h00);
      st_nxt.status[7]       = 1'b0;
      st_nxt.irq = |(st_nxt.status[ST_BREAKPOINT:ST_COND_LO] &
                     st_nxt.mask[ST_BREAKPOINT:ST_COND_LO]);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r        <= '0;
         st_r.phase  <= PH_CMD;
         st_r.mask   <= MASK_RST;
         st_r.status <= STATUS_RST;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign status     = st_r.status;
   assign host_irq   = st_r.irq;
   assign traj_act   = st_r.act;
   assign traj_start = st_r.start_p;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_word_in(phase_type ph);
      clk_en && word_done && st_r.phase == ph;
   endsequence

   property p_mask_load;
      s_word_in(PH_MASK) |=> st_r.mask == {1'b0, $past(word[6:1]), 1'b0} && st_r.phase == PH_CMD;
   endproperty
   a_mask_load: assert property (p_mask_load) else $error("mask word not loaded");

   property p_poll_unmasked;
      clk_en && |cond_evt |=> (st_r.status[5:1] & $past(cond_evt)) == $past(cond_evt);
   endproperty
   a_poll_unmasked: assert property (p_poll_unmasked) else $error("condition lost");

   property p_bp_flag;
      clk_en && bp_hit |=> st_r.status[ST_BREAKPOINT] && !st_r.bp_armed;
   endproperty
   a_bp_flag: assert property (p_bp_flag) else $error("breakpoint flag not set");

   property p_mask40;
      st_r.mask == 8'h40 && st_r.irq |-> st_r.status[ST_BREAKPOINT];
   endproperty
   a_mask40: assert property (p_mask40) else $error("interrupt from masked condition");

   property p_bp_rel;
      clk_en && bp_load && st_r.bp_rel |=> st_r.bp == $past(target_pos) + $past(val32);
   endproperty
   a_bp_rel: assert property (p_bp_rel) else $error("relative breakpoint wrong");

   property p_byte_pair;
      clk_en && data_evt && !st_r.byte_hi |=> st_r.byte_hi && st_r.hi_byte == $past(hin.data);
   endproperty
   a_byte_pair: assert property (p_byte_pair) else $error("high byte not held");

   sequence s_busy_run;
      st_r.status[ST_BUSY] [*8];
   endsequence

   property p_busy_cmd;
      clk_en && cmd_evt ##1 clk_en |-> s_busy_run;
   endproperty
   a_busy_cmd: assert property (p_busy_cmd) else $error("busy not raised");

   property p_busy_ignore;
      clk_en && st_r.status[ST_BUSY]
         |=> $stable(st_r.phase) && $stable(st_r.byte_hi) && $stable(st_r.mask);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("transfer taken while busy");

   property p_start_only;
      !st_r.start_p |-> $stable(st_r.act) or !$past(rst_b);
   endproperty
   a_start_only: assert property (p_start_only) else $error("trajectory changed without start");

   property p_flag_sticky;
      clk_en && st_r.status[ST_BREAKPOINT] && !(st_r.phase == PH_CLEAR && word_done)
         |=> st_r.status[ST_BREAKPOINT];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("breakpoint flag dropped");

   property p_hit_on_tick;
      $rose(st_r.status[ST_BREAKPOINT]) |-> $past(tick) && $past(st_r.bp_armed);
   endproperty
   a_hit_on_tick: assert property (p_hit_on_tick) else $error("compare off sample");

endmodule : motion_host_cmd

`default_nettype wire

// >>> tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host processor on the command and data ports
module host_bus_model (
   // clock and device status
   input  wire logic       sys_clk,
   input  wire logic [7:0] status,
   // host port pins
   output var  logic       cmd_wr,
   output var  logic       data_wr,
   output var  logic [7:0] data
);
   initial begin
      cmd_wr  = 1'b0;
      data_wr = 1'b0;
      data    = 8'h00;
   end

   // data is synchronised with the strobe, so it is held 4 clocks on both sides
   task automatic put_byte(input logic cmd, input logic [7:0] b, input logic busy_exp,
                           output logic ok);
      int   n;
      logic seen;
      seen = 1'b0;
      @(negedge sys_clk);
      data = b;
      repeat (4) @(negedge sys_clk);
      if (cmd) begin
         cmd_wr = 1'b1;
      end else begin
         data_wr = 1'b1;
      end
      for (n = 0; n < 8; n++) begin
         @(negedge sys_clk);
         seen = seen | (status[0] === 1'b1);
      end
      cmd_wr  = 1'b0;
      data_wr = 1'b0;
      repeat (4) @(negedge sys_clk);
      // released bus shows a changed value, never the last byte
      data = ~b;
      n = 0;
      while (status[0] !== 1'b0 && n < 30) begin
         @(negedge sys_clk);
         n++;
      end
      ok = (seen === busy_exp) && (n < 30);
   endtask : put_byte

   task automatic put_cmd(input logic [7:0] code, output logic ok);
      put_byte(1'b1, code, 1'b1, ok);
   endtask : put_cmd

   task automatic put_word(input logic [15:0] w, output logic ok);
      logic ok_h;
      logic ok_l;
      put_byte(1'b0, w[15:8], 1'b0, ok_h);
      put_byte(1'b0, w[7:0], 1'b1, ok_l);
      ok = ok_h & ok_l;
   endtask : put_word
endmodule : host_bus_model

`default_nettype wire

// >>> tb/tb_motion_host_cmd.sv
`timescale 1ns/1ps
`default_nettype none

module tb_motion_host_cmd;
   import motion_cmd_pkg::*;

   logic        sys_clk;
   logic        rst_b;
   logic        clk_en;
   logic        host_cmd_wr;
   logic        host_data_wr;
   logic [7:0]  host_data;
   logic [31:0] actual_pos;
   logic [31:0] target_pos;
   logic [5:1]  cond_evt;
   logic [7:0]  status;
   logic        host_irq;
   traj_type    traj_act;
   logic        traj_start;
   logic        ok;
   int          error_cnt;
   int          check_count;
   int          starts;
   int          cyc;

   motion_host_cmd u_motion_host_cmd (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .clk_en       (clk_en),
      .host_cmd_wr  (host_cmd_wr),
      .host_data_wr (host_data_wr),
      .host_data    (host_data),
      .actual_pos   (actual_pos),
      .target_pos   (target_pos),
      .cond_evt     (cond_evt),
      .status       (status),
      .host_irq     (host_irq),
      .traj_act     (traj_act),
      .traj_start   (traj_start)
   );

   host_bus_model u_host_bus_model (
      .sys_clk (sys_clk),
      .status  (status),
      .cmd_wr  (host_cmd_wr),
      .data_wr (host_data_wr),
      .data    (host_data)
   );

   always #5 sys_clk = ~sys_clk;

   always @(negedge sys_clk) begin
      if (traj_start === 1'b1) begin
         starts++;
      end
   end

   // ==========================================================
   // checking and closing
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   // the longest test waits about three sample periods; the ceiling leaves ample room
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 80000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ==========================================================
   // host access helpers
   task automatic cmd(input logic [7:0] code);
      u_host_bus_model.put_cmd(code, ok);
      chk("command handshake", 1, ok);
   endtask : cmd

   task automatic word(input logic [15:0] w);
      u_host_bus_model.put_word(w, ok);
      chk("word handshake", 1, ok);
   endtask : word

   task automatic dword(input logic [31:0] v);
      word(v[31:16]);
      word(v[15:0]);
   endtask : dword

   task automatic wait_bp(input int lim);
      int n;
      n = 0;
      while (status[6] !== 1'b1 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_bp

   // ==========================================================
   // main sequence
   initial begin
      sys_clk = 1'b0;
      rst_b = 1'b0;
      clk_en = 1'b1;
      actual_pos = 32'h0000_0000;
      target_pos = 32'h0000_0005;
      cond_evt = 5'h00;
      error_cnt = 0;
      check_count = 0;
      starts = 0;
      cyc = 0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("reset outputs", 0, {status, host_irq, traj_start, traj_act});
      $display("test reset done");

      // breakpoint-only mask, high byte must be ignored
      cmd(CMD_MASK);
      word(16'hFF40);
      cond_evt[1] = 1'b1;
      @(negedge sys_clk);
      cond_evt[1] = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("status cond1", 1, status[1]);
      chk("irq masked cond1", 0, host_irq);
      $display("test mask done");

      // absolute breakpoint must ignore target_pos
      cmd(CMD_BP_ABS);
      dword(32'h0002_7100);
      actual_pos = 32'h0002_7100;
      wait_bp(3 * 2048 + 20);
      chk("abs bp flag", 1, status[6]);
      @(negedge sys_clk);
      chk("abs bp irq", 1, host_irq);
      actual_pos = 32'h0000_0000;
      repeat (2100) @(negedge sys_clk);
      chk("flag sticks", 2'b11, {status[6], host_irq});
      $display("test abs breakpoint done");

      cmd(CMD_FLAG_CLEAR);
      word(16'hFF00);
      repeat (2) @(negedge sys_clk);
      chk("flags cleared", 7'h00, {status[6:1], host_irq});
      $display("test clear done");

      // relative breakpoint: offset plus target
      actual_pos = 32'd80000;
      target_pos = 32'd10;
      cmd(CMD_BP_REL);
      dword(32'h0001_3880);
      repeat (2 * 2048 + 20) @(negedge sys_clk);
      chk("rel bp early", 0, status[6]);
      actual_pos = 32'd80010;
      wait_bp(3 * 2048 + 20);
      chk("rel bp flag", 1, status[6]);
      $display("test rel breakpoint done");

      // absolute acceleration and velocity, held until start
      cmd(CMD_TRAJ_LOAD);
      word(16'h1828);
      dword(32'h0000_0011);
      dword(32'h0002_753F);
      chk("before start", 0, traj_act);
      cmd(CMD_TRAJ_START);
      chk("start pulses", 1, starts);
      chk("traj abs", {16'h1828, 32'h0000_0011, 32'h0002_753F, 32'h0}, traj_act);
      $display("test traj abs done");

      // relative velocity adds to the running one
      cmd(CMD_TRAJ_LOAD);
      word(16'h180C);
      dword(32'h0002_0C4A);
      chk("vel before start", 32'h0002_753F, traj_act.vel);
      cmd(CMD_TRAJ_START);
      chk("traj rel", {16'h180C, 32'h0000_0011, 32'h0004_8189, 32'h0}, traj_act);
      $display("test traj rel done");

      // relative position adds target; a repeated start re-adds nothing
      cmd(CMD_TRAJ_LOAD);
      word(16'h002B);
      dword(32'h0000_0011);
      dword(32'h0002_753F);
      dword(32'hFFFE_2B40);
      cmd(CMD_TRAJ_START);
      chk("pos", {16'h002B, 32'h0000_0011, 32'h0002_753F, 32'hFFFE_2B4A}, traj_act);
      cmd(CMD_TRAJ_START);
      chk("again", {16'h0000, 32'h0000_0011, 32'h0002_753F, 32'hFFFE_2B4A}, traj_act);
      chk("start pulses", 4, starts);
      $display("test traj pos done");
      report_and_stop();
   end
endmodule : tb_motion_host_cmd

`default_nettype wire
